// ### hdl/eeprom_spi_pkg.sv
// shared constants and types for the serial eeprom command interface
package eeprom_spi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

    ////////////////////////////////////////////////////////////////////////////
    // status_and_protect field positions
    localparam int SR_PROTECT_PIN_ENABLE = 7;
    localparam int SR_BLOCK_PROTECT_HI = 3;
    localparam int SR_BLOCK_PROTECT_LO = 2;
    localparam int SR_WRITE_ENABLE_LATCH = 1;
    localparam int SR_BUSY = 0;
    localparam logic SR_WEL_RESET = 1'b0;
    localparam logic SR_BUSY_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // array geometry and protected block bases
    localparam int ARRAY_ADDR_W = 10;
    localparam int ARRAY_WORDS = 1024;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_IDX_W = 5;
    localparam logic [ARRAY_ADDR_W-1:0] QUARTER_BASE = 10'h300;
    localparam logic [ARRAY_ADDR_W-1:0] HALF_BASE = 10'h200;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int INTERNAL_WRITE_TIME_MS = 5;
    // longest time, so rounded down
    localparam int INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int WRITE_TIMER_W = 20;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDR = 3'b001,
        PH_WDATA = 3'b010,
        PH_SRDATA = 3'b011,
        PH_STATUS = 3'b100,
        PH_RDATA = 3'b101,
        PH_IGNORE = 3'b110
    } phase_t;

    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_WEL_SET = 3'b001,
        CMD_WEL_CLR = 3'b010,
        CMD_SR_WRITE = 3'b011,
        CMD_ARRAY_WRITE = 3'b100
    } cmd_t;

    typedef enum logic [0:0] {
        ST_READY = 1'b0,
        ST_WRITING = 1'b1
    } core_state_t;

endpackage : eeprom_spi_pkg

// ### hdl/sync_two_ff.sv
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st.meta = d;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st.stable;
endmodule : sync_two_ff

// ### hdl/spi_serial_eeprom_interface.sv
// spi slave command interface of a small serial eeprom
//
// Functional notes
// - input bits are sampled on the rising serial clock edge in both modes.
// - output changes to its next bit on the falling serial clock edge.
// - chip select high floats the output; a running internal write continues.
// - hold low with clock low pauses; hold high resumes without retransmission.
// - write-protect pin high never blocks a write.
// - pin low with protect enable set rejects status register writes.
// - first byte of a frame shifts into the 8-bit instruction register.
// - only the six defined opcodes act; any other byte does nothing.
// - 06h sets the write enable latch, 04h clears it.
// - 05h returns status, 01h writes status.
// - 03h reads the array, 02h writes the array.
// - array read takes an address and returns data from there onward.
// - busy is 1 during the internal write, 0 after; host cannot write it.
// - latch 1 permits writes, 0 forbids; set and cleared by its opcodes.
// - block protect bits change only by status write and are nonvolatile.
// - array writes into protected blocks are refused.
// - status is pin-enable, 0, 0, 0, protect hi, protect lo, latch, busy.
// - internal write starts at chip select rising and lasts at most 5 ms.
// - during an internal write only the status read is accepted.
// - end of an internal write clears the write enable latch.
// - status write changes only bits 7, 3 and 2.
// - page load wraps within 32 bytes, page address fixed.
`timescale 1ns/1ps
module spi_serial_eeprom_interface
    import eeprom_spi_pkg::*;
#(
    parameter int WRITE_CYCLES = INTERNAL_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic [2:0] nvProtectIn,
    output logic so,
    output logic soOe,
    output logic [2:0] nvProtectOut
);

    ////////////////////////////////////////////////////////////////////////////
    // state types

    typedef struct packed {
        logic tag;
        phase_t phase;
        logic [2:0] bitCnt;
        logic [7:0] shiftIn;
        logic addrByte;
        logic isRead;
        logic [15:0] addr;
        logic [PAGE_IDX_W-1:0] pageIdx;
        logic [PAGE_BYTES-1:0] loaded;
        logic [PAGE_BYTES-1:0][7:0] pageBuf;
        cmd_t cmd;
        logic [7:0] srNew;
    } rise_t;

    typedef struct packed {
        logic started;
        logic [2:0] cnt;
        logic [7:0] shiftOut;
        logic [ARRAY_ADDR_W-1:0] ptr;
        logic so;
        logic soOe;
    } fall_t;

    typedef struct packed {
        core_state_t state;
        logic write_enable_latch;
        logic [1:0] bp;
        logic protect_pin_enable;
        logic [WRITE_TIMER_W-1:0] timer;
        logic [PAGE_IDX_W:0] progIdx;
        cmd_t kind;
        logic [ARRAY_ADDR_W-PAGE_IDX_W-1:0] pageAddr;
        logic [7:0] srNew;
        logic csPrev;
        logic lastTag;
        logic [2:0] nvOut;
        logic linkReset;
    } core_t;

    rise_t rise;
    rise_t next_rise;
    rise_t riseBase;
    fall_t fall;
    fall_t next_fall;
    core_t core;
    core_t next_core;
    logic frameOpen;
    logic [7:0] inByte;
    logic [7:0] byteOut;
    logic [7:0] statusClk;
    logic [7:0] statusSck;
    logic [ARRAY_ADDR_W-1:0] readPtr;
    logic csSync;
    logic tagSync;
    logic wpSync;
    logic csRise;
    logic commitNow;
    logic pageProtected;
    logic [7:0] mem [ARRAY_WORDS];

    localparam logic [WRITE_TIMER_W-1:0] WRITE_LAST = WRITE_TIMER_W'(WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // crossings

    sync_two_ff #(.WIDTH(3)) u_sync_clk (
        .clk(clk),
        .d({csN, rise.tag, wpN}),
        .q({csSync, tagSync, wpSync})
    );

    // status is quasi-static while a frame runs; a few edges of lag are harmless
    sync_two_ff #(.WIDTH(8)) u_sync_sck (
        .clk(sck),
        .d(statusClk),
        .q(statusSck)
    );

    always_comb begin
        statusClk = 8'h00;
        statusClk[SR_PROTECT_PIN_ENABLE] = core.protect_pin_enable;
        statusClk[SR_BLOCK_PROTECT_HI] = core.bp[1];
        statusClk[SR_BLOCK_PROTECT_LO] = core.bp[0];
        statusClk[SR_WRITE_ENABLE_LATCH] = core.write_enable_latch;
        statusClk[SR_BUSY] = (core.state == ST_WRITING);
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side, rising edge: opcode, address and data capture

    // cleared while deselected, so the first edge of a frame sees a fresh decoder
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            frameOpen <= 1'b0;
        end else begin
            frameOpen <= 1'b1;
        end
    end

    always_comb begin
        riseBase = rise;
        if (!frameOpen) begin
            riseBase.tag = ~rise.tag;
            riseBase.phase = PH_OPCODE;
            riseBase.bitCnt = 3'd0;
            riseBase.addrByte = 1'b0;
            riseBase.cmd = CMD_NONE;
        end
        next_rise = riseBase;
        inByte = {riseBase.shiftIn[6:0], si};
        if (holdN) begin
            next_rise.shiftIn = inByte;
            next_rise.bitCnt = riseBase.bitCnt + 3'd1;
            if (riseBase.bitCnt == 3'd7) begin
                case (riseBase.phase)
                    PH_OPCODE: begin
                        next_rise.phase = PH_IGNORE;
                        if (statusSck[SR_BUSY] && inByte != OP_STATUS_READ) begin
                            next_rise.phase = PH_IGNORE;
                        end else if (inByte == OP_WRITE_ENABLE) begin
                            next_rise.cmd = CMD_WEL_SET;
                        end else if (inByte == OP_WRITE_DISABLE) begin
                            next_rise.cmd = CMD_WEL_CLR;
                        end else if (inByte == OP_STATUS_READ) begin
                            next_rise.phase = PH_STATUS;
                        end else if (inByte == OP_STATUS_WRITE) begin
                            next_rise.phase = PH_SRDATA;
                        end else if (inByte == OP_ARRAY_READ) begin
                            next_rise.phase = PH_ADDR;
                            next_rise.isRead = 1'b1;
                        end else if (inByte == OP_ARRAY_WRITE) begin
                            next_rise.phase = PH_ADDR;
                            next_rise.isRead = 1'b0;
                            next_rise.loaded = '0;
                        end
                    end
                    PH_ADDR: begin
                        next_rise.addr = {riseBase.addr[7:0], inByte};
                        next_rise.addrByte = 1'b1;
                        next_rise.pageIdx = inByte[PAGE_IDX_W-1:0];
                        if (riseBase.addrByte) begin
                            next_rise.phase = riseBase.isRead ? PH_RDATA : PH_WDATA;
                        end
                    end
                    PH_WDATA: begin
                        next_rise.pageBuf[riseBase.pageIdx] = inByte;
                        next_rise.loaded[riseBase.pageIdx] = 1'b1;
                        next_rise.pageIdx = riseBase.pageIdx + 5'd1;
                        next_rise.cmd = CMD_ARRAY_WRITE;
                    end
                    PH_SRDATA: begin
                        next_rise.srNew = inByte;
                        next_rise.cmd = CMD_SR_WRITE;
                        next_rise.phase = PH_IGNORE;
                    end
                    default: begin
                    end
                endcase
            end
        end
        // sck may run for other slaves
        if (csN) begin
            next_rise = rise;
        end
    end

    // held over chip select high so the clock side can take the command
    always_ff @(posedge sck or posedge core.linkReset) begin
        if (core.linkReset) begin
            rise <= '0;
        end else begin
            rise <= next_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side, falling edge: serial output

    always_comb begin
        next_fall = fall;
        readPtr = fall.started ? fall.ptr : rise.addr[ARRAY_ADDR_W-1:0];
        // array only changes while busy, when reads are refused
        byteOut = (rise.phase == PH_STATUS) ? statusSck : mem[readPtr];
        if (holdN && frameOpen && (rise.phase == PH_STATUS || rise.phase == PH_RDATA)) begin
            next_fall.soOe = 1'b1;
            if (!fall.started || fall.cnt == 3'd0) begin
                next_fall.so = byteOut[7];
                next_fall.shiftOut = {byteOut[6:0], 1'b0};
                next_fall.cnt = 3'd7;
                next_fall.started = 1'b1;
                if (rise.phase == PH_RDATA) begin
                    next_fall.ptr = readPtr + 10'd1;
                end
            end else begin
                next_fall.so = fall.shiftOut[7];
                next_fall.shiftOut = {fall.shiftOut[6:0], 1'b0};
                next_fall.cnt = fall.cnt - 3'd1;
            end
        end
    end

    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            fall <= '0;
        end else begin
            fall <= next_fall;
        end
    end

    assign so = fall.so;
    assign soOe = fall.soOe;

    ////////////////////////////////////////////////////////////////////////////
    // clock side: command commit and self-timed write

    always_comb begin
        case (core.bp)
            2'b01: pageProtected = ({rise.addr[9:5], 5'd0} >= QUARTER_BASE);
            2'b10: pageProtected = ({rise.addr[9:5], 5'd0} >= HALF_BASE);
            2'b11: pageProtected = 1'b1;
            default: pageProtected = 1'b0;
        endcase
    end

    // the tag tells a clocked frame from a bare chip select pulse
    assign csRise = !core.csPrev && csSync;
    assign commitNow = csRise && (tagSync != core.lastTag) && (rise.bitCnt == 3'd0);

    always_comb begin
        next_core = core;
        next_core.csPrev = csSync;
        next_core.linkReset = 1'b0;
        if (csRise) begin
            next_core.lastTag = tagSync;
        end
        case (core.state)
            ST_READY: begin
                if (commitNow) begin
                    if (rise.cmd == CMD_WEL_SET) begin
                        next_core.write_enable_latch = 1'b1;
                    end else if (rise.cmd == CMD_WEL_CLR) begin
                        next_core.write_enable_latch = 1'b0;
                    end else if (rise.cmd == CMD_SR_WRITE && core.write_enable_latch
                                 && !(core.protect_pin_enable && !wpSync)) begin
                        next_core.state = ST_WRITING;
                        next_core.kind = CMD_SR_WRITE;
                        next_core.srNew = rise.srNew;
                        next_core.timer = '0;
                    end else if (rise.cmd == CMD_ARRAY_WRITE && core.write_enable_latch
                                 && !pageProtected) begin
                        next_core.state = ST_WRITING;
                        next_core.kind = CMD_ARRAY_WRITE;
                        next_core.pageAddr = rise.addr[9:5];
                        next_core.progIdx = '0;
                        next_core.timer = '0;
                    end
                end
            end
            ST_WRITING: begin
                next_core.timer = core.timer + 20'd1;
                if (!core.progIdx[PAGE_IDX_W]) begin
                    next_core.progIdx = core.progIdx + 6'd1;
                end
                if (core.timer == WRITE_LAST) begin
                    next_core.state = ST_READY;
                    next_core.write_enable_latch = 1'b0;
                    if (core.kind == CMD_SR_WRITE) begin
                        next_core.protect_pin_enable = core.srNew[SR_PROTECT_PIN_ENABLE];
                        next_core.bp[1] = core.srNew[SR_BLOCK_PROTECT_HI];
                        next_core.bp[0] = core.srNew[SR_BLOCK_PROTECT_LO];
                        next_core.nvOut = {core.srNew[SR_PROTECT_PIN_ENABLE],
                                           core.srNew[SR_BLOCK_PROTECT_HI],
                                           core.srNew[SR_BLOCK_PROTECT_LO]};
                    end
                end
            end
            default: begin
                next_core.state = ST_READY;
            end
        endcase
    end

    // protect bits are reloaded from the nonvolatile store while in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core <= '0;
            core.state <= ST_READY;
            core.write_enable_latch <= SR_WEL_RESET;
            core.protect_pin_enable <= nvProtectIn[2];
            core.bp <= nvProtectIn[1:0];
            core.nvOut <= nvProtectIn;
            core.linkReset <= 1'b1;
        end else begin
            core <= next_core;
        end
    end

    assign nvProtectOut = core.nvOut;

    // one loaded byte programmed per clock at the start of the cycle
    always_ff @(posedge clk) begin
        if (core.state == ST_WRITING && core.kind == CMD_ARRAY_WRITE
            && !core.progIdx[PAGE_IDX_W] && rise.loaded[core.progIdx[PAGE_IDX_W-1:0]]) begin
            mem[{core.pageAddr, core.progIdx[PAGE_IDX_W-1:0]}] <=
                rise.pageBuf[core.progIdx[PAGE_IDX_W-1:0]];
        end
    end

endmodule : spi_serial_eeprom_interface

// ### dv/spi_host_model.sv
// host side serial controller model for the eeprom link
`timescale 1ns/1ps
module spi_host_model (
    output logic sck,
    output logic csN,
    output logic si,
    output logic holdN,
    input wire logic so,
    input wire logic soOe
);
    logic idle = 1'b0;
    initial begin
        sck = 1'b0;
        csN = 1'b0;
        si = 1'b0;
        holdN = 1'b1;
        #2 csN = 1'b1; // real edge clears link flops
    end
    ////////////////////////////////////////////////////////////
    // mode 0 idles low, mode 3 idles high; 32 ns link period
    task automatic start(input logic mode3);
        #3; // off the system clock edges
        idle = mode3;
        sck = mode3;
        #16;
        csN = 1'b0;
        #16;
    endtask : start
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            #16;
            sck = 1'b1;
            rx[i] = soOe ? so : 1'bz;
            #16;
        end
    endtask : xbyte
    task automatic pause();
        sck = 1'b0;
        #16;
        holdN = 1'b0;
        repeat (2) begin
            sck = 1'b1;
            si = ~si;
            #16 sck = 1'b0;
            #16;
        end
        holdN = 1'b1;
        #16;
    endtask : pause
    task automatic stop();
        sck = idle;
        #16;
        csN = 1'b1;
        si = ~si; // stale data never looks valid
        #48;
    endtask : stop
endmodule : spi_host_model

// ### dv/eeprom_spi_sva.sv
// port checker for the serial eeprom command interface
`timescale 1ns/1ps
module eeprom_spi_sva
    import eeprom_spi_pkg::*;
#(
    parameter int WRITE_CYCLES = INTERNAL_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic so,
    input wire logic soOe,
    input wire logic [2:0] nvProtectOut
);
    logic [8:0] bitCount;
    logic [7:0] opcode;
    logic [20:0] wpLowCount;
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            bitCount <= 9'h000;
            opcode <= 8'h00;
        end else if (holdN) begin
            bitCount <= bitCount + {8'h00, bitCount != 9'h1FF};
            if (bitCount < 9'h008) opcode <= {opcode[6:0], si};
        end
    end
    // counts from the raw pin, so any write begun before it fell is long over
    always_ff @(posedge clk) begin
        if (!rst_n || wpN) wpLowCount <= 21'h000000;
        else if (wpLowCount != '1) wpLowCount <= wpLowCount + 21'h000001;
    end
    ////////////////////////////////////////////////////////////
    a_float_when_idle: assert property (@(posedge clk) disable iff (!rst_n)
        csN && $past(csN) |-> !soOe) else $error("output enabled while deselected");
    a_quiet_opcode: assert property (@(posedge sck) disable iff (csN)
        bitCount < 9'h008 |-> !soOe) else $error("output driven during opcode");
    a_quiet_address: assert property (@(posedge sck) disable iff (csN)
        opcode == OP_ARRAY_READ && bitCount < 9'h018 |-> !soOe)
        else $error("output driven during address");
    a_bad_op_silent: assert property (@(posedge sck) disable iff (csN)
        bitCount > 9'h008 && opcode != OP_ARRAY_READ && opcode != OP_STATUS_READ |-> !soOe)
        else $error("output driven for non-read opcode");
    a_status_drives: assert property (@(posedge sck) disable iff (csN)
        opcode == OP_STATUS_READ && bitCount inside {[8:15]} |-> soOe)
        else $error("status not driven");
    a_status_zero_bits: assert property (@(posedge sck) disable iff (csN)
        opcode == OP_STATUS_READ && bitCount inside {[9:11]} |-> so == 1'b0)
        else $error("status bits 6 to 4 not zero");
    a_so_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
        soOe && $past(soOe) && !$fell(sck) |-> $stable(so))
        else $error("output changed off the falling edge");
    a_prot_locked: assert property (@(posedge clk) disable iff (!rst_n)
        wpLowCount > 21'(WRITE_CYCLES + 16) && nvProtectOut[2] |=> $stable(nvProtectOut))
        else $error("protect bits changed while locked");
    c_status: cover property (@(posedge sck) opcode == OP_STATUS_READ && bitCount == 9'h010);
    c_read: cover property (@(posedge sck) opcode == OP_ARRAY_READ && bitCount == 9'h020);
    c_locked: cover property (@(posedge clk) wpLowCount > 21'(WRITE_CYCLES + 16));
endmodule : eeprom_spi_sva
bind spi_serial_eeprom_interface eeprom_spi_sva #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_spi_sva_i (
    .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .wpN(wpN),
    .so(so), .soOe(soOe), .nvProtectOut(nvProtectOut)
);

// ### dv/tb.sv
// self-checking bench for the serial eeprom command interface
`timescale 1ns/1ps
module tb;
    import eeprom_spi_pkg::*;
    localparam int WC = 400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wpN = 1'b1;
    logic [2:0] nvProtectIn = 3'h0;
    logic sck, csN, si, holdN, so, soOe;
    logic [2:0] nvProtectOut;
    int n_mismatch = 0;
    int compares = 0;
    spi_serial_eeprom_interface #(.WRITE_CYCLES(WC)) spi_serial_eeprom_interface_i (
        .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN),
        .wpN(wpN), .nvProtectIn(nvProtectIn), .so(so), .soOe(soOe),
        .nvProtectOut(nvProtectOut)
    );
    spi_host_model spi_host_model_i (
        .sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so), .soOe(soOe)
    );
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic op_only(input logic m3, input logic [7:0] op);
        logic [7:0] r;
        spi_host_model_i.start(m3);
        spi_host_model_i.xbyte(op, r);
        spi_host_model_i.stop();
    endtask : op_only
    task automatic rd_status(input logic m3, output logic [7:0] st);
        logic [7:0] r;
        spi_host_model_i.start(m3);
        spi_host_model_i.xbyte(OP_STATUS_READ, r);
        spi_host_model_i.xbyte(8'h00, st);
        spi_host_model_i.stop();
    endtask : rd_status
    task automatic wait_ready();
        logic [7:0] st;
        for (int k = 0; k < 40; k++) begin
            rd_status(1'b0, st);
            if (st[SR_BUSY] === 1'b0) return;
        end
        check("busy", st, 8'h00);
    endtask : wait_ready
    // opcode and address go out in mode 3, data lands wherever the rules put it
    task automatic wr_frame(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d[$]);
        logic [7:0] r;
        op_only(1'b0, OP_WRITE_ENABLE);
        spi_host_model_i.start(1'b1);
        spi_host_model_i.xbyte(op, r);
        if (op == OP_ARRAY_WRITE) spi_host_model_i.xbyte(a[15:8], r);
        if (op == OP_ARRAY_WRITE) spi_host_model_i.xbyte(a[7:0], r);
        foreach (d[i]) spi_host_model_i.xbyte(d[i], r);
        spi_host_model_i.stop();
    endtask : wr_frame
    task automatic rd_array(input logic [15:0] a, input logic [7:0] e[$]);
        logic [7:0] r;
        spi_host_model_i.start(1'b0);
        spi_host_model_i.xbyte(OP_ARRAY_READ, r);
        spi_host_model_i.xbyte(a[15:8], r);
        spi_host_model_i.xbyte(a[7:0], r);
        foreach (e[i]) begin
            spi_host_model_i.xbyte(8'h00, r);
            check("array data", r, e[i]);
        end
        spi_host_model_i.stop();
    endtask : rd_array
    ////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        logic [7:0] st;
        rd_status(1'b0, st);
        check("status", st, 8'h00);
        check("output enable", {7'h00, soOe}, 8'h00);
        $display("test reset_state done");
    endtask : t_reset_state
    task automatic t_latch();
        logic [7:0] st;
        logic [7:0] bad[4] = '{8'h00, 8'hFF, 8'h86, 8'h0B};
        op_only(1'b1, OP_WRITE_ENABLE);
        rd_status(1'b1, st);
        check("status", st, 8'h02);
        foreach (bad[i]) begin
            op_only(1'b0, bad[i]);
            rd_status(1'b1, st);
            check("status", st, 8'h02);
        end
        op_only(1'b1, OP_WRITE_DISABLE);
        rd_status(1'b1, st);
        check("status", st, 8'h00);
        $display("test latch done");
    endtask : t_latch
    task automatic t_page_wrap();
        logic [7:0] st;
        wr_frame(OP_ARRAY_WRITE, 16'hFC1E, '{8'hA0, 8'hA1, 8'hA2, 8'hA3});
        rd_status(1'b0, st);
        check("status", st, 8'h03);
        op_only(1'b0, OP_WRITE_ENABLE);
        rd_array(16'h001E, '{8'hZZ});
        wait_ready();
        rd_status(1'b0, st);
        check("status", st, 8'h00);
        rd_array(16'h001E, '{8'hA0, 8'hA1});
        rd_array(16'h0000, '{8'hA2, 8'hA3});
        $display("test page_wrap done");
    endtask : t_page_wrap
    task automatic t_protect();
        logic [7:0] st;
        wr_frame(OP_STATUS_WRITE, 16'h0000, '{8'hFF});
        wait_ready();
        rd_status(1'b0, st);
        check("status", st, 8'h8C);
        check("stored protect", {5'h00, nvProtectOut}, 8'h07);
        @(posedge clk) rst_n <= 1'b0;
        nvProtectIn <= 3'h7;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_status(1'b0, st);
        check("status", st, 8'h8C);
        wr_frame(OP_ARRAY_WRITE, 16'h0000, '{8'h5A});
        wait_ready();
        rd_array(16'h0000, '{8'hA2});
        @(posedge clk) wpN <= 1'b0;
        repeat (4) @(posedge clk);
        wr_frame(OP_STATUS_WRITE, 16'h0000, '{8'h00});
        repeat (WC + 40) @(posedge clk);
        rd_status(1'b0, st);
        check("status", st & 8'hFC, 8'h8C);
        @(posedge clk) wpN <= 1'b1;
        repeat (4) @(posedge clk);
        wr_frame(OP_STATUS_WRITE, 16'h0000, '{8'h00});
        wait_ready();
        rd_status(1'b0, st);
        check("status", st, 8'h00);
        check("stored protect", {5'h00, nvProtectOut}, 8'h00);
        $display("test protect done");
    endtask : t_protect
    task automatic t_hold();
        logic [7:0] st;
        op_only(1'b1, OP_WRITE_ENABLE);
        spi_host_model_i.start(1'b1);
        spi_host_model_i.xbyte(OP_STATUS_READ, st);
        spi_host_model_i.pause();
        spi_host_model_i.xbyte(8'h00, st);
        spi_host_model_i.stop();
        check("status", st, 8'h02);
        $display("test hold done");
    endtask : t_hold
    task automatic t_partial();
        wr_frame(OP_ARRAY_WRITE, 16'h0300, '{8'h11});
        wait_ready();
        wr_frame(OP_STATUS_WRITE, 16'h0000, '{8'h04});
        wait_ready();
        wr_frame(OP_ARRAY_WRITE, 16'h02FF, '{8'h33});
        wait_ready();
        wr_frame(OP_ARRAY_WRITE, 16'h0300, '{8'h22});
        rd_array(16'h02FF, '{8'h33, 8'h11});
        wr_frame(OP_STATUS_WRITE, 16'h0000, '{8'h08});
        wait_ready();
        wr_frame(OP_ARRAY_WRITE, 16'h02FF, '{8'h44});
        rd_array(16'h02FF, '{8'h33});
        $display("test partial done");
    endtask : t_partial
    ////////////////////////////////////////////////////////////
    initial begin
        #500us;
        n_mismatch++;
        $display("wrong value watchdog expected done seen hung");
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_state();
        t_latch();
        t_page_wrap();
        t_protect();
        t_hold();
        t_partial();
        final_report();
    end
endmodule : tb
